// *** include/aps_pkg.sv ***
package aps_pkg;

   localparam int unsigned SLOT_COUNT = 64;
   localparam int unsigned SLOT_W     = 6;
   localparam int unsigned TOTAL_W    = 7;
   localparam int unsigned REP_W      = 9;
   localparam int unsigned PARAM_W    = 32;
   localparam int unsigned ADR_W      = 8;

   // ------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [ADR_W-1:0] OFF_CTRL   = 8'h00;
   localparam logic [ADR_W-1:0] OFF_TOTAL  = 8'h04;
   localparam logic [ADR_W-1:0] OFF_SLOT   = 8'h08;
   localparam logic [ADR_W-1:0] OFF_REPEAT = 8'h0c;
   localparam logic [ADR_W-1:0] OFF_CMD    = 8'h10;
   localparam logic [ADR_W-1:0] OFF_ACTIVE = 8'h14;
   localparam logic [ADR_W-1:0] OFF_STATUS = 8'h18;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int unsigned CTRL_ON_BIT     = 0;
   localparam int unsigned CTRL_SCHEME_LSB = 1;
   localparam int unsigned CMD_SAVE_BIT    = 0;
   localparam int unsigned CMD_LOAD_BIT    = 1;
   localparam int unsigned STAT_RUN_BIT    = 0;
   localparam int unsigned STAT_DRAIN_BIT  = 1;
   localparam int unsigned STAT_SLOT_LSB   = 8;
   localparam int unsigned STAT_USED_LSB   = 16;

   // ------------------------------------------------------------
   // reset values and limits
   // ------------------------------------------------------------
   localparam logic [TOTAL_W-1:0] TOTAL_RST   = 7'h01;
   localparam logic [TOTAL_W-1:0] TOTAL_MIN   = 7'h01;
   localparam logic [TOTAL_W-1:0] TOTAL_MAX   = 7'h40;
   localparam logic [SLOT_W-1:0]  SLOT_RST    = 6'h00;
   localparam logic [REP_W-1:0]   REP_RST     = 9'h001;
   localparam logic [REP_W-1:0]   REP_MIN     = 9'h001;
   localparam logic [REP_W-1:0]   REP_MAX     = 9'h100;
   localparam logic [PARAM_W-1:0] PARAM_RST   = 32'h0000_0000;
   localparam logic [PARAM_W-1:0] PARAM_DFLT  = 32'h0000_0000;

   typedef enum logic [1:0] {
      APS_SCHEME_AUTO       = 2'h0,
      APS_SCHEME_CONTROLLED = 2'h1,
      APS_SCHEME_FREE       = 2'h2
   } aps_scheme_t;

   // one stored parameter set
   typedef struct packed {
      logic [REP_W-1:0]   repeats;
      logic [PARAM_W-1:0] params;
   } aps_set_t;

   localparam aps_set_t SET_DFLT = '{repeats: REP_MIN, params: PARAM_DFLT};

   // one wishbone request as seen by the slave
   typedef struct packed {
      logic             we;
      logic [3:0]       sel;
      logic [ADR_W-1:0] adr;
      logic [31:0]      dat;
   } aps_wb_req_t;

endpackage

// *** src/aps_slot_store.sv ***
`timescale 1ns/100ps
module aps_slot_store (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       wr_en_i,
   input  wire logic [aps_pkg::SLOT_W-1:0] wr_slot_i,
   input  wire aps_pkg::aps_set_t          wr_set_i,
   input  wire logic [aps_pkg::SLOT_W-1:0] rd_a_slot_i,
   output aps_pkg::aps_set_t               rd_a_set_o,
   input  wire logic [aps_pkg::SLOT_W-1:0] rd_b_slot_i,
   output aps_pkg::aps_set_t               rd_b_set_o
);

   aps_pkg::aps_set_t                   mem [aps_pkg::SLOT_COUNT];
   logic [aps_pkg::SLOT_COUNT-1:0]      saved_reg;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // only the saved flags reset; contents are lost with them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         saved_reg <= '0;
      end else if (wr_en_i) begin
         saved_reg[wr_slot_i] <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_slot_i] <= wr_set_i;
      end
   end

   // ------------------------------------------------------------
   // read ports
   // ------------------------------------------------------------
   assign rd_a_set_o = saved_reg[rd_a_slot_i] ? mem[rd_a_slot_i]
                                              : aps_pkg::SET_DFLT;
   assign rd_b_set_o = saved_reg[rd_b_slot_i] ? mem[rd_b_slot_i]
                                              : aps_pkg::SET_DFLT;

endmodule

// *** src/aps_sequencer.sv ***
`timescale 1ns/100ps
module aps_sequencer (
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [aps_pkg::ADR_W-1:0]   wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic      [31:0]                 wb_dat_o,
   output logic                             wb_ack_o,
   // frame side
   input  wire logic                        frame_trig_i,
   input  wire logic                        frame_busy_i,
   output logic      [aps_pkg::PARAM_W-1:0] active_params_o,
   output logic      [aps_pkg::SLOT_W-1:0]  current_slot_o,
   output logic                             seq_running_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [aps_pkg::TOTAL_W-1:0] clamp_total(
      input logic [31:0] v
   );
      if (v[31:aps_pkg::TOTAL_W] != '0 ||
          v[aps_pkg::TOTAL_W-1:0] > aps_pkg::TOTAL_MAX) begin
         clamp_total = aps_pkg::TOTAL_MAX;
      end else if (v[aps_pkg::TOTAL_W-1:0] < aps_pkg::TOTAL_MIN) begin
         clamp_total = aps_pkg::TOTAL_MIN;
      end else begin
         clamp_total = v[aps_pkg::TOTAL_W-1:0];
      end
   endfunction

   function automatic logic [aps_pkg::REP_W-1:0] clamp_rep(
      input logic [31:0] v
   );
      if (v[31:aps_pkg::REP_W] != '0 ||
          v[aps_pkg::REP_W-1:0] > aps_pkg::REP_MAX) begin
         clamp_rep = aps_pkg::REP_MAX;
      end else if (v[aps_pkg::REP_W-1:0] < aps_pkg::REP_MIN) begin
         clamp_rep = aps_pkg::REP_MIN;
      end else begin
         clamp_rep = v[aps_pkg::REP_W-1:0];
      end
   endfunction

   // merge written bytes over the old word
   function automatic logic [31:0] merge_lanes(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel
   );
      merge_lanes = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            merge_lanes[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
   endfunction

   // one offset compare, shared by the write and the read decode
   function automatic logic adr_hit(
      input logic [aps_pkg::ADR_W-1:0] adr,
      input logic [aps_pkg::ADR_W-1:0] off
   );
      adr_hit = (adr == off);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_RUN,
      ST_DRAIN
   } aps_state_t;

   aps_state_t                     state_reg;
   aps_state_t                     state_next;
   logic                           on_reg;
   logic [1:0]                     scheme_reg;
   logic [aps_pkg::TOTAL_W-1:0]    total_reg;
   logic [aps_pkg::SLOT_W-1:0]     sel_slot_reg;
   logic [aps_pkg::REP_W-1:0]      rep_reg;
   logic [aps_pkg::PARAM_W-1:0]    active_reg;
   logic [aps_pkg::PARAM_W-1:0]    active_next;
   logic [aps_pkg::PARAM_W-1:0]    shadow_reg;
   logic [aps_pkg::SLOT_W-1:0]     cur_reg;
   logic [aps_pkg::SLOT_W-1:0]     cur_next;
   logic [aps_pkg::REP_W-1:0]      cur_rep_reg;
   logic [aps_pkg::REP_W-1:0]      cur_rep_next;
   logic [aps_pkg::REP_W-1:0]      used_reg;
   logic [aps_pkg::REP_W-1:0]      used_next;
   logic                           ack_reg;
   logic [31:0]                    rdat_reg;
   logic                           running_reg;

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   aps_pkg::aps_wb_req_t           req;
   wire                            req_new;
   wire                            wr_stb;
   wire                            wr_ctrl;
   wire                            wr_total;
   wire                            wr_slot;
   wire                            wr_rep;
   wire                            wr_cmd;
   wire                            wr_active;
   wire [31:0]                     wr_word;
   wire [31:0]                     rd_mux;
   wire [31:0]                     stat_word;
   wire                            save_cmd;
   wire                            load_cmd;
   wire                            hit_ctrl;
   wire                            hit_total;
   wire                            hit_slot;
   wire                            hit_rep;
   wire                            hit_cmd;
   wire                            hit_active;
   wire                            hit_status;
   wire [31:0]                     ctrl_word;

   assign req = '{we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

   assign hit_ctrl   = adr_hit(req.adr, aps_pkg::OFF_CTRL);
   assign hit_total  = adr_hit(req.adr, aps_pkg::OFF_TOTAL);
   assign hit_slot   = adr_hit(req.adr, aps_pkg::OFF_SLOT);
   assign hit_rep    = adr_hit(req.adr, aps_pkg::OFF_REPEAT);
   assign hit_cmd    = adr_hit(req.adr, aps_pkg::OFF_CMD);
   assign hit_active = adr_hit(req.adr, aps_pkg::OFF_ACTIVE);
   assign hit_status = adr_hit(req.adr, aps_pkg::OFF_STATUS);

   // a request is served once, at the edge that raises ack
   assign req_new   = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr_stb    = req_new & req.we;
   assign wr_ctrl   = wr_stb & hit_ctrl;
   assign wr_total  = wr_stb & hit_total;
   assign wr_slot   = wr_stb & hit_slot;
   assign wr_rep    = wr_stb & hit_rep;
   assign wr_cmd    = wr_stb & hit_cmd;
   assign wr_active = wr_stb & hit_active;
   assign wr_word   = merge_lanes(32'h0000_0000, req.dat, req.sel);

   assign save_cmd = wr_cmd & wr_word[aps_pkg::CMD_SAVE_BIT];
   assign load_cmd = wr_cmd & wr_word[aps_pkg::CMD_LOAD_BIT];

   assign stat_word =
      ({31'h0000_0000, state_reg != ST_IDLE} << aps_pkg::STAT_RUN_BIT)
    | ({31'h0000_0000, state_reg == ST_DRAIN} << aps_pkg::STAT_DRAIN_BIT)
    | ({26'h000_0000, cur_reg} << aps_pkg::STAT_SLOT_LSB)
    | ({23'h00_0000, used_reg} << aps_pkg::STAT_USED_LSB);

   assign ctrl_word =
      ({30'h0000_0000, scheme_reg} << aps_pkg::CTRL_SCHEME_LSB)
    | ({31'h0000_0000, on_reg} << aps_pkg::CTRL_ON_BIT);

   // unmapped offsets answer with zero
   assign rd_mux =
      hit_ctrl   ? ctrl_word                    :
      hit_total  ? {25'h000_0000, total_reg}    :
      hit_slot   ? {26'h000_0000, sel_slot_reg} :
      hit_rep    ? {23'h00_0000, rep_reg}       :
      hit_active ? active_reg                   :
      hit_status ? stat_word                    :
                   32'h0000_0000;

   // ------------------------------------------------------------
   // slot storage
   // ------------------------------------------------------------
   aps_pkg::aps_set_t              sel_set;
   aps_pkg::aps_set_t              seq_set;
   aps_pkg::aps_set_t              save_set;
   wire [aps_pkg::SLOT_W-1:0]      seq_rd_slot;
   wire                            at_last;
   wire [aps_pkg::SLOT_W-1:0]      nxt_slot;

   assign save_set = '{repeats: rep_reg, params: active_reg};

   // last index of the cycle is total minus one
   assign at_last  = ({1'b0, cur_reg} ==
                      7'(total_reg - aps_pkg::TOTAL_MIN));
   assign nxt_slot = at_last ? aps_pkg::SLOT_RST
                             : 6'(cur_reg + 6'h01);
   // idle reads slot 0 so that enabling can load it at once
   assign seq_rd_slot = (state_reg == ST_IDLE) ? aps_pkg::SLOT_RST
                                               : nxt_slot;

   aps_slot_store u_store (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .wr_en_i     (save_cmd),
      .wr_slot_i   (sel_slot_reg),
      .wr_set_i    (save_set),
      .rd_a_slot_i (sel_slot_reg),
      .rd_a_set_o  (sel_set),
      .rd_b_slot_i (seq_rd_slot),
      .rd_b_set_o  (seq_set)
   );

   // ------------------------------------------------------------
   // sequencing
   // ------------------------------------------------------------
   wire                            enable_evt;
   wire                            used_up;
   wire                            take_trig;
   wire                            advance;

   // only the auto scheme is built; other schemes never start
   assign enable_evt = on_reg &
                       (scheme_reg == 2'(aps_pkg::APS_SCHEME_AUTO));
   assign used_up    = (used_reg >= cur_rep_reg);
   // a trigger is not taken once on_reg is low; one in the cycle of the write that clears it is still taken
   assign take_trig  = frame_trig_i & on_reg;
   assign advance    = take_trig & used_up;

   always_comb begin
      state_next   = state_reg;
      cur_next     = cur_reg;
      cur_rep_next = cur_rep_reg;
      used_next    = used_reg;
      active_next  = active_reg;
      if (wr_active) begin
         active_next = merge_lanes(active_reg, req.dat, req.sel);
      end
      if (load_cmd && state_reg == ST_IDLE) begin
         active_next = sel_set.params;
      end
      unique case (state_reg)
         ST_IDLE: begin
            if (enable_evt) begin
               state_next   = ST_ARMED;
               cur_next     = aps_pkg::SLOT_RST;
               cur_rep_next = seq_set.repeats;
               used_next    = '0;
               active_next  = seq_set.params;
            end
         end
         ST_ARMED: begin
            if (!on_reg) begin
               state_next = frame_busy_i ? ST_DRAIN : ST_IDLE;
            end else if (frame_trig_i) begin
               // first frame keeps set 0, no advance
               state_next = ST_RUN;
               used_next  = 9'(used_reg + 9'h001);
            end
         end
         ST_RUN: begin
            if (!on_reg) begin
               state_next = frame_busy_i ? ST_DRAIN : ST_IDLE;
            end else if (take_trig && !used_up) begin
               used_next = 9'(used_reg + 9'h001);
            end else if (advance) begin
               cur_next     = nxt_slot;
               cur_rep_next = seq_set.repeats;
               used_next    = 9'h001;
               active_next  = seq_set.params;
            end
         end
         ST_DRAIN: begin
            // triggers are ignored while the last frame drains
            if (!frame_busy_i) begin
               state_next = ST_IDLE;
            end
         end
      endcase
      if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
         active_next = shadow_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg   <= ST_IDLE;
         cur_reg     <= aps_pkg::SLOT_RST;
         cur_rep_reg <= aps_pkg::REP_RST;
         used_reg    <= '0;
         active_reg  <= aps_pkg::PARAM_RST;
         shadow_reg  <= aps_pkg::PARAM_RST;
         running_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         cur_reg     <= cur_next;
         cur_rep_reg <= cur_rep_next;
         used_reg    <= used_next;
         active_reg  <= active_next;
         running_reg <= (state_next != ST_IDLE);
         if (state_reg == ST_IDLE && enable_evt) begin
            shadow_reg <= active_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         on_reg       <= 1'b0;
         scheme_reg   <= 2'(aps_pkg::APS_SCHEME_AUTO);
         total_reg    <= aps_pkg::TOTAL_RST;
         sel_slot_reg <= aps_pkg::SLOT_RST;
         rep_reg      <= aps_pkg::REP_RST;
      end else begin
         if (wr_ctrl && req.sel[0]) begin
            on_reg     <= req.dat[aps_pkg::CTRL_ON_BIT];
            scheme_reg <= req.dat[aps_pkg::CTRL_SCHEME_LSB +: 2];
         end
         if (wr_total) begin
            total_reg <= clamp_total(wr_word);
         end
         if (wr_slot && req.sel[0]) begin
            sel_slot_reg <= req.dat[aps_pkg::SLOT_W-1:0];
         end
         if (wr_rep) begin
            rep_reg <= clamp_rep(merge_lanes({23'h00_0000, rep_reg},
                                             req.dat, req.sel));
         end
      end
   end

   // ------------------------------------------------------------
   // bus answer and outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ack_reg  <= req_new;
         rdat_reg <= (req_new && !req.we) ? rd_mux : 32'h0000_0000;
      end
   end

   assign wb_ack_o        = ack_reg;
   assign wb_dat_o        = rdat_reg;
   assign active_params_o = active_reg;
   assign current_slot_o  = cur_reg;
   assign seq_running_o   = running_reg;

endmodule

// *** testbench/aps_frame_src.sv ***
`timescale 1ns/100ps
module aps_frame_src (
   input  wire logic clk_i,
   output logic      trig_o,
   output logic      busy_o
);
   // ------------------------------------------------------------
   // frame trigger source
   // ------------------------------------------------------------
   initial begin
      trig_o = 1'b0;
      busy_o = 1'b0;
   end
   // one-cycle pulse; caller lets an edge pass before the next one
   task pulse();
      trig_o <= 1'b1;
      @(posedge clk_i);
      trig_o <= 1'b0;
   endtask
   task set_busy(input logic b);
      busy_o <= b;
   endtask
endmodule

// *** testbench/aps_sequencer_monitor.sv ***
`timescale 1ns/100ps
module aps_sequencer_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        frame_trig_i,
   input wire logic        frame_busy_i,
   input wire logic [31:0] active_params_o,
   input wire logic [5:0]  current_slot_o,
   input wire logic        seq_running_o
);
   // ------------------------------------------------------------
   // port checks
   // ------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_follows: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   chk_enable_zero: assert property (
      $rose(seq_running_o) |-> current_slot_o == 6'h00)
      else $error("run did not start at slot zero");
   chk_slot_hold: assert property (
      seq_running_o && !frame_trig_i ##1 seq_running_o
      |-> $stable(current_slot_o))
      else $error("slot moved without trigger");
   chk_slot_step: assert property (
      seq_running_o && frame_trig_i ##1 seq_running_o
      |-> current_slot_o == $past(current_slot_o)
       || current_slot_o == $past(current_slot_o) + 6'h01
       || current_slot_o == 6'h00)
      else $error("slot jumped out of order");
   chk_drain_hold: assert property (
      seq_running_o && frame_busy_i |=> seq_running_o)
      else $error("stopped during a frame");
   // idle params change only through a bus write
   chk_idle_params: assert property (
      !seq_running_o && !(wb_cyc_i && wb_stb_i && wb_we_i)
      |=> $stable(active_params_o))
      else $error("active params moved while idle");
endmodule

bind aps_sequencer aps_sequencer_monitor u_mon (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .frame_trig_i,
   .frame_busy_i, .active_params_o, .current_slot_o, .seq_running_o);

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [31:0] dat;
   logic [31:0] dat_o;
   logic        ack;
   logic        trig;
   logic        busy;
   logic [31:0] active;
   logic [5:0]  slot;
   logic        run;
   logic [31:0] q;
   int          mismatches;
   int          cmp_count;
   logic [31:0] pv [4] = '{32'h0000_1111, 32'h0000_2222, 32'h0000_3333,
                           32'h0000_0000};
   int          rep [4] = '{1, 3, 2, 1};
   logic [31:0] pre = 32'h0000_abcd;

   aps_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .frame_trig_i(trig), .frame_busy_i(busy), .active_params_o(active),
      .current_slot_o(slot), .seq_running_o(run));
   aps_frame_src src (.clk_i(clk_i), .trig_o(trig), .busy_o(busy));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   initial clk_i = 1'b0;
   always #5 clk_i = ~clk_i;

   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask
   // entered just after a rising edge; ack and data taken at an edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      // no cycle count assumed; the watchdog ends a hung wait
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      @(posedge clk_i);
   endtask
   task frame(input int s, input logic [31:0] p);
      src.pulse();
      @(negedge clk_i);
      check({26'h0, slot}, 32'(s));
      check(active, p);
      @(posedge clk_i);
   endtask
   task do_reset();
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task stop_test();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task test_reset_vals();
      logic [7:0]  oa [7];
      logic [31:0] oe [7];
      oa = '{aps_pkg::OFF_TOTAL, aps_pkg::OFF_SLOT, aps_pkg::OFF_REPEAT,
             aps_pkg::OFF_ACTIVE, aps_pkg::OFF_STATUS, aps_pkg::OFF_CMD,
             8'h1c};
      oe = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
      for (int i = 0; i < 7; i++) begin
         xfer(1'b0, oa[i], 32'h0);
         check(q, oe[i]);
      end
      $display("reset values done");
   endtask
   task test_limits();
      logic [7:0]  la [4];
      logic [31:0] lw [4];
      logic [31:0] le [4];
      la = '{aps_pkg::OFF_TOTAL, aps_pkg::OFF_TOTAL, aps_pkg::OFF_REPEAT,
             aps_pkg::OFF_REPEAT};
      lw = '{32'h0, 32'h64, 32'h0, 32'h12c};
      le = '{32'h1, 32'h40, 32'h1, 32'h100};
      for (int i = 0; i < 4; i++) begin
         xfer(1'b1, la[i], lw[i]);
         xfer(1'b0, la[i], 32'h0);
         check(q, le[i]);
      end
      $display("limits done");
   endtask
   task test_config();
      xfer(1'b1, aps_pkg::OFF_CTRL, 32'h0);
      xfer(1'b1, aps_pkg::OFF_TOTAL, 32'h4);
      xfer(1'b1, aps_pkg::OFF_SLOT, 32'h2);
      xfer(1'b1, aps_pkg::OFF_ACTIVE, 32'h0000_dead);
      xfer(1'b1, aps_pkg::OFF_CMD, 32'h1);
      for (int i = 0; i < 3; i++) begin
         xfer(1'b1, aps_pkg::OFF_SLOT, 32'(i));
         xfer(1'b1, aps_pkg::OFF_REPEAT, 32'(rep[i]));
         xfer(1'b1, aps_pkg::OFF_ACTIVE, pv[i]);
         xfer(1'b1, aps_pkg::OFF_CMD, 32'h1);
      end
      for (int i = 1; i < 4; i += 2) begin
         xfer(1'b1, aps_pkg::OFF_SLOT, 32'(i));
         xfer(1'b1, aps_pkg::OFF_CMD, 32'h2);
         xfer(1'b0, aps_pkg::OFF_ACTIVE, 32'h0);
         check(q, pv[i]);
      end
      xfer(1'b1, aps_pkg::OFF_ACTIVE, pre);
      $display("config done");
   endtask
   task test_run();
      int s;
      int u;
      s = 0;
      u = 0;
      xfer(1'b1, aps_pkg::OFF_CTRL, 32'h1);
      @(negedge clk_i);
      check({31'h0, run}, 32'h1);
      check(active, pv[0]);
      @(posedge clk_i);
      for (int n = 0; n < 11; n++) begin
         if (u == 0) u = 1;
         else if (u < rep[s]) u++;
         else begin
            s = (s + 1) % 4;
            u = 1;
         end
         frame(s, pv[s]);
      end
      xfer(1'b0, aps_pkg::OFF_STATUS, 32'h0);
      check(q & 32'h01ff_3f03, (u << 16) | (s << 8) | 1);
      src.set_busy(1'b1);
      xfer(1'b1, aps_pkg::OFF_CTRL, 32'h0);
      @(negedge clk_i);
      check({31'h0, run}, 32'h1);
      @(posedge clk_i);
      frame(s, pv[s]);
      src.set_busy(1'b0);
      @(posedge clk_i);
      @(negedge clk_i);
      check({31'h0, run}, 32'h0);
      check(active, pre);
      @(posedge clk_i);
      $display("run and drain done");
   endtask
   task test_schemes();
      for (int s = 1; s < 3; s++) begin
         xfer(1'b1, aps_pkg::OFF_CTRL, {29'h0, 2'(s), 1'b1});
         @(negedge clk_i);
         check({31'h0, run}, 32'h0);
         @(posedge clk_i);
         xfer(1'b1, aps_pkg::OFF_CTRL, 32'h0);
      end
      $display("schemes done");
   endtask
   task test_volatile();
      do_reset();
      xfer(1'b1, aps_pkg::OFF_ACTIVE, 32'h0000_5555);
      xfer(1'b1, aps_pkg::OFF_CTRL, 32'h1);
      @(negedge clk_i);
      check(active, 32'h0);
      @(posedge clk_i);
      frame(0, 32'h0);
      frame(0, 32'h0);
      xfer(1'b1, aps_pkg::OFF_CTRL, 32'h0);
      @(negedge clk_i);
      check(active, 32'h0000_5555);
      @(posedge clk_i);
      $display("volatile done");
   endtask

   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      mismatches = 0;
      cmp_count = 0;
      do_reset();
      test_reset_vals();
      test_limits();
      test_config();
      test_run();
      test_schemes();
      test_volatile();
      stop_test();
   end
   // far more than the scenarios need
   initial begin
      #100000;
      mismatches++;
      stop_test();
   end
endmodule
